//--- test/flash_seq_monitor.sv
// Concurrent checks on the link that joins the two flash sequencer ends.
// Assumes one pclk domain; tb instantiates it beside the interface.
`timescale 1ns/100ps
`default_nettype none
module flash_seq_monitor (
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     wr_stb,
    input wire flash_seq_pkg::req_kind_e wr_kind,
    input wire logic [7:0]               wr_data,
    input wire logic                     from_bdm,
    input wire logic                     secured,
    input wire logic                     stop_mode,
    input wire logic [7:0]               status,
    input wire logic [6:0]               divider,
    input wire logic                     pump_on,
    input wire logic                     busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire cmd_wr = wr_stb && wr_kind == flash_seq_pkg::REQ_CMD;
    wire code_ok = wr_data inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
    property p_div_lock; status[0] |=> $stable(divider); endproperty
    a_div_lock: assert property (p_div_lock) else $error("divider moved");
    property p_div_err;
        wr_stb && wr_kind == flash_seq_pkg::REQ_DIV && status[4] |=> $stable(divider);
    endproperty
    a_div_err: assert property (p_div_err) else $error("divider taken");
    property p_nodiv;
        wr_stb && wr_kind == flash_seq_pkg::REQ_ARRAY && !status[0] |=> status[4];
    endproperty
    a_nodiv: assert property (p_nodiv) else $error("early array write");
    property p_badcode; cmd_wr && !code_ok |=> status[4]; endproperty
    a_badcode: assert property (p_badcode) else $error("bad code taken");
    property p_secure;
        cmd_wr && from_bdm && secured && wr_data inside {8'h20, 8'h25, 8'h40} |=> status[4];
    endproperty
    a_secure: assert property (p_secure) else $error("secured code taken");
    property p_stop; busy && stop_mode |-> ##[1:2] (!busy && status[4]); endproperty
    a_stop: assert property (p_stop) else $error("stop did not abort");
    property p_done; $fell(busy) |-> status[6] || status[4]; endproperty
    a_done: assert property (p_done) else $error("no completion");
    property p_idle_pump; (status[7] && !busy) [*2] |-> !pump_on; endproperty
    a_idle_pump: assert property (p_idle_pump) else $error("pump left on");
    property p_err_blocks; status[4] && !busy |=> !busy; endproperty
    a_err_blocks: assert property (p_err_blocks) else $error("ran with error");
    c_launch: cover property ($rose(busy));
    c_error: cover property ($rose(status[4]));
    c_pump: cover property ($rose(pump_on));
endmodule : flash_seq_monitor
`default_nettype wire

//--- test/tb.sv
// Bench: APB master on the host end, device end joined by the link.
// Assumes the design files compile first; one 20 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_map.svh"
module tb;
    localparam logic [11:0] DIV = `OFF_DIVIDER;
    localparam logic [11:0] STA = `OFF_STATUS;
    localparam logic [11:0] CMD = `OFF_COMMAND;
    localparam logic [11:0] ADR = `OFF_ARRAY_ADDR;
    localparam logic [11:0] DAT = `OFF_ARRAY_DATA;
    localparam logic [11:0] MOD = `OFF_MODE;
    localparam logic [11:0] NOP = 12'h100;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sl, dr, hv, high_voltage;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, r;
    logic [15:0] array_addr;
    logic [7:0]  array_data, active_cmd;
    logic [7:0]  bad [3] = '{8'h20, 8'h25, 8'h40};
    int          n_mismatch, samples_checked, m_set, m_err, n, i;
    flash_seq_if link ();
    flash_seq_host u_flash_seq_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
    flash_seq_device u_flash_seq_device (.pclk(pclk), .presetn(presetn), .link(link.device),
        .array_addr(array_addr), .array_data(array_data), .active_cmd(active_cmd),
        .high_voltage(high_voltage));
    flash_seq_monitor u_flash_seq_monitor (.pclk(pclk), .presetn(presetn),
        .wr_stb(link.wr_stb), .wr_kind(link.wr_kind), .wr_data(link.wr_data),
        .from_bdm(link.from_bdm), .secured(link.secured), .stop_mode(link.stop_mode),
        .status(link.status), .divider(link.divider), .pump_on(link.pump_on),
        .busy(link.busy));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    // Starts one edge late so psel never gets two assignments in one time step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        sl = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd_st(input string nm);
        apb(1'b0, STA, 32'h0);
        chk(nm, {24'h0, 2'b11, 1'b0, m_err[0], 3'b000, m_set[0]}, rd);
    endtask : rd_st
    task automatic go(input logic [15:0] ga, input logic [7:0] gd, input logic [7:0] gc);
        wr(ADR, 32'(ga));
        wr(DAT, 32'(gd));
        wr(CMD, 32'(gc));
        wr(STA, 32'h80);
    endtask : go
    // Counts busy cycles; dr notes a pump drop before the whole queue finished.
    task automatic run();
        n = 0;
        dr = 1'b0;
        for (i = 0; i < 10 && link.busy !== 1'b1; i++) @(posedge pclk);
        hv = high_voltage;
        while (!(link.busy === 1'b0 && link.status[7] === 1'b1) && n < 30000) begin
            @(posedge pclk);
            if (link.status[7] !== 1'b1 && link.pump_on !== 1'b1) dr = 1'b1;
            n++;
        end
    endtask : run
    task automatic tm(input string nm, input int e);
        chk(nm, 32'(e), 32'((n >= e - 2 && n <= e + 3) ? e : n));
    endtask : tm
    task automatic ec(input logic [11:0] o2, input logic [31:0] d2,
                      input logic [11:0] o3, input logic [31:0] d3);
        r = $urandom;
        wr(DAT, r);
        wr(o2, d2);
        wr(o3, d3);
        m_err = 1;
        rd_st("err_set");
        wr(STA, 32'h10);
        m_err = 0;
        rd_st("err_clear");
    endtask : ec
    task automatic burst(input logic [5:0] lo, input int e);
        r = $urandom;
        go({r[15:6], lo}, r[7:0], 8'h25);
        fork
            run();
            go({r[15:6], lo} + 16'h1, r[15:8], 8'h25);
        join
        tm("burst_time", e);
    endtask : burst
    task automatic rst();
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        m_set = 0;
        m_err = 0;
    endtask : rst
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        #4000000;
        n_mismatch++;
        conclude();
    end
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        void'($urandom(30));
        rst();
        rd_st("reset_status");
        apb(1'b0, NOP, 32'h0);
        chk("unmapped_err", 32'h1, 32'(sl));
        wr(DAT, 32'h5A);
        m_err = 1;
        rd_st("early_array");
        wr(DIV, 32'd99);
        apb(1'b0, DIV, 32'h0);
        chk("div_while_err", 32'h0, rd);
        wr(STA, 32'h10);
        m_err = 0;
        rd_st("err_w1c");
        wr(DIV, 32'd99);
        m_set = 1;
        wr(DIV, 32'd5);
        apb(1'b0, DIV, 32'h0);
        chk("div_once", 32'd99, rd);
        ec(CMD, 32'h20, STA, 32'h0);
        ec(DAT, 32'h1, NOP, 32'h0);
        ec(CMD, 32'h20, CMD, 32'h20);
        ec(DIV, 32'd99, NOP, 32'h0);
        ec(CMD, 32'h20, DIV, 32'd99);
        ec(CMD, 32'h21, NOP, 32'h0);
        r = $urandom;
        go(r[15:0], r[23:16], 8'h20);
        run();
        tm("prog_time", 900);
        chk("hv_prog", 32'h1, 32'(hv));
        chk("latched_addr", 32'(r[15:0]), 32'(array_addr));
        chk("latched_data", 32'(r[23:16]), 32'(array_data));
        chk("latched_cmd", 32'h20, 32'(active_cmd));
        go(r[15:0], r[7:0], 8'h05);
        run();
        chk("blank_hv", 32'h0, 32'(hv));
        rd_st("blank_done");
        burst(6'($urandom_range(62, 1)), 1300);
        chk("pump_hold", 32'h0, 32'(dr));
        chk("pump_off", 32'h0, 32'(link.pump_on));
        burst(6'h3F, 1800);
        go(r[15:0], r[7:0], 8'h25);
        go(r[15:0] + 16'h1, r[7:0], 8'h25);
        wr(DAT, r);
        apb(1'b0, STA, 32'h0);
        chk("busy_array", 32'h1, 32'(rd[4]));
        run();
        wr(STA, 32'h10);
        rst();
        // Shortest tick keeps the erase runs within the time budget.
        wr(DIV, 32'h0);
        m_set = 1;
        go(r[15:0], r[31:24], 8'h40);
        run();
        tm("page_time", 4000);
        wr(MOD, 32'h6);
        go(r[31:16], r[7:0], 8'h41);
        run();
        tm("mass_time", 20000);
        for (int j = 0; j < 3; j++) ec(CMD, 32'(bad[j]), STA, 32'h80);
        go(r[15:0], r[7:0], 8'h05);
        run();
        rd_st("secure_blank");
        wr(MOD, 32'h0);
        go(r[15:0], r[7:0], 8'h40);
        wr(MOD, 32'h1);
        run();
        chk("stop_abort", 32'h1, 32'(n < 100));
        apb(1'b0, STA, 32'h0);
        chk("stop_err", 32'h1, 32'(rd[4]));
        conclude();
    end
endmodule : tb
`default_nettype wire

//--- verilog/erase_program_timing_clock_divider.sv
// Tick generator for the erase/program timing clock, one pclk pulse per period.
// Assumes pclk and presetn of the device end.
`timescale 1ns/100ps
`default_nettype none
module erase_program_timing_clock_divider (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic [6:0] div,
    output logic            tick
);
    logic [6:0] cnt_reg;
    // Period is div+1 pclk cycles; restarted whenever the sequencer idles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 7'h00;
        end else if (!run || cnt_reg == div) begin
            cnt_reg <= 7'h00;
        end else begin
            cnt_reg <= cnt_reg + 7'h01;
        end
    end
    assign tick = run && (cnt_reg == div);
endmodule : erase_program_timing_clock_divider
`default_nettype wire

//--- verilog/flash_seq_device.sv
// Flash program/erase command sequencer: protocol checker, timer and pump control.
// Assumes writes arrive as one-cycle strobes on pclk from the controller end.
// How it works
// [R1] Software sets divider for 150-200 kHz timing.
// [R2] Divider accepts one write after reset only.
// [R3] Divider writes ignored while access error set.
// [R4] Byte program 9 ticks, burst 4 ticks.
// [R5] Page erase 4000 ticks, mass 20000.
// [R6] Sequence starts with one latched array write.
// [R7] Erase and blank check ignore data.
// [R8] Only five command codes recognised and latched.
// [R9] Writing one to buffer-empty launches command.
// [R10] Writing zero to buffer-empty aborts, flags error.
// [R11] Complete flag shows launched command finished.
// [R12] Pump stays on for queued same-row burst.
// [R13] First burst byte or new row: standard time.
// [R14] No queued burst: pump and high voltage off.
// [R15] Error cleared by writing one; blocks commands.
// [R16] Array write before divider set: error.
// [R17] Array write while buffer full: error.
// [R18] Second array or command write: error.
// [R19] Out-of-order control writes set error.
// [R20] Unknown command code sets error.
// [R21] Stop mode aborts running command with error.
// [R22] Secured debug path: only blank/mass erase.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_map.svh"
module flash_seq_device (
    input  wire logic      pclk,
    input  wire logic      presetn,
    flash_seq_if.device    link,
    output logic [15:0]    array_addr,
    output logic [7:0]     array_data,
    output logic [7:0]     active_cmd,
    output logic           high_voltage
);
    flash_seq_pkg::seq_state_e state_reg;
    logic [6:0]  div_reg;
    logic        div_set_reg;
    logic        accerr_reg;
    logic        cbef_reg;
    logic        ccf_reg;
    logic [15:0] addr_reg;
    logic [7:0]  data_reg;
    logic [7:0]  cmd_reg;
    logic [15:0] run_addr_reg;
    logic [7:0]  run_data_reg;
    logic [7:0]  run_cmd_reg;
    logic [14:0] ticks_reg;
    logic        pump_reg;
    logic        queued_reg;
    logic [1:0]  stage_reg;
    logic        in_load;
    logic        in_cmd;
    logic        tick;
    logic        wr_array;
    logic        wr_cmd;
    logic        wr_stat;
    logic        wr_div;
    logic        launch;
    logic        abort;
    logic        err_set;
    logic        done;
    logic        code_ok;
    logic        burst_keep;

    function automatic logic valid_code(input logic [7:0] c, input logic bdm, input logic sec);
        logic ok;
        ok = (c == `CMD_BLANK) || (c == `CMD_BYTE_PROG) || (c == `CMD_BURST_PROG) ||
             (c == `CMD_PAGE_ERASE) || (c == `CMD_MASS_ERASE); // [R8] [R20]
        if (bdm && sec && !(c == `CMD_BLANK || c == `CMD_MASS_ERASE)) begin
            ok = 1'b0; // [R22]
        end
        return ok;
    endfunction : valid_code

    function automatic logic [14:0] op_ticks(input logic [7:0] c, input logic short_burst);
        logic [14:0] t;
        t = 15'(`TICKS_BYTE); // [R4]
        case (c)
            `CMD_BURST_PROG: t = short_burst ? 15'(`TICKS_BURST) : 15'(`TICKS_BYTE); // [R13]
            `CMD_PAGE_ERASE: t = 15'(`TICKS_PAGE); // [R5]
            `CMD_MASS_ERASE: t = 15'(`TICKS_MASS); // [R5]
            default:         t = 15'(`TICKS_BYTE);
        endcase
        return t;
    endfunction : op_ticks

    erase_program_timing_clock_divider u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (state_reg == flash_seq_pkg::ST_RUN),
        .div     (div_reg),
        .tick    (tick)
    );

    assign wr_array = link.wr_stb && link.wr_kind == flash_seq_pkg::REQ_ARRAY;
    assign wr_cmd   = link.wr_stb && link.wr_kind == flash_seq_pkg::REQ_CMD;
    assign wr_stat  = link.wr_stb && link.wr_kind == flash_seq_pkg::REQ_STATUS;
    assign wr_div   = link.wr_stb && link.wr_kind == flash_seq_pkg::REQ_DIV;
    assign code_ok  = valid_code(link.wr_data, link.from_bdm, link.secured);
    assign in_load  = state_reg == flash_seq_pkg::ST_LOADED || stage_reg == 2'h1;
    assign in_cmd   = state_reg == flash_seq_pkg::ST_CMDSET || stage_reg == 2'h2;
    assign launch   = wr_stat && link.wr_data[`BIT_CBEF] && !accerr_reg && in_cmd; // [R9] [R15]
    assign abort    = wr_stat && !link.wr_data[`BIT_CBEF] && (in_load || in_cmd); // [R10]
    assign done     = state_reg == flash_seq_pkg::ST_RUN && tick && ticks_reg == 15'h0001;
    // A burst byte may follow without pump shutdown only inside one 64-byte row.
    assign burst_keep = queued_reg && cmd_reg == `CMD_BURST_PROG &&
                        addr_reg[15:6] == run_addr_reg[15:6] && addr_reg[5:0] != 6'h00; // [R12]

    always_comb begin
        err_set = 1'b0;
        if (wr_array && (!div_set_reg || !cbef_reg || accerr_reg)) begin
            err_set = 1'b1; // [R16] [R17]
        end
        if (wr_array && (in_load || in_cmd)) begin
            err_set = 1'b1; // [R18]
        end
        if (wr_cmd && (!in_load || !code_ok)) begin
            err_set = 1'b1; // [R18] [R19] [R20] [R22]
        end
        if (abort || (wr_stat && in_load) || (wr_div && (in_load || in_cmd))) begin
            err_set = 1'b1; // [R10] [R19]
        end
        if (link.stop_mode && state_reg == flash_seq_pkg::ST_RUN) begin
            err_set = 1'b1; // [R21]
        end
    end

    // Divider: one write only, and never while the error flag stands.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg     <= `DIVIDER_RESET;
            div_set_reg <= 1'b0;
        end else if (wr_div && !div_set_reg && !accerr_reg && !err_set) begin // [R2] [R3]
            div_reg     <= link.wr_data[6:0];
            div_set_reg <= 1'b1;
        end
    end

    // Set wins over a clear arriving in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accerr_reg <= 1'b0;
        end else if (err_set) begin
            accerr_reg <= 1'b1;
        end else if (wr_stat && link.wr_data[`BIT_ACCERR]) begin
            accerr_reg <= 1'b0; // [R15]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= flash_seq_pkg::ST_IDLE;
            addr_reg     <= 16'h0000;
            data_reg     <= 8'h00;
            cmd_reg      <= 8'h00;
            cbef_reg     <= 1'b1;
            queued_reg   <= 1'b0;
            run_addr_reg <= 16'h0000;
            run_data_reg <= 8'h00;
            run_cmd_reg  <= 8'h00;
            ticks_reg    <= 15'h0000;
            stage_reg    <= 2'h0;
        end else begin
            case (state_reg)
                flash_seq_pkg::ST_IDLE: begin
                    if (wr_array && !err_set) begin
                        addr_reg  <= link.wr_addr; // [R6] [R7]
                        data_reg  <= link.wr_data;
                        state_reg <= flash_seq_pkg::ST_LOADED;
                    end
                end
                flash_seq_pkg::ST_LOADED: begin
                    if (err_set) begin
                        state_reg <= flash_seq_pkg::ST_IDLE;
                    end else if (wr_cmd) begin
                        cmd_reg   <= link.wr_data; // [R8]
                        state_reg <= flash_seq_pkg::ST_CMDSET;
                    end
                end
                flash_seq_pkg::ST_CMDSET: begin
                    if (err_set) begin
                        state_reg <= flash_seq_pkg::ST_IDLE;
                    end else if (launch) begin
                        run_addr_reg <= addr_reg;
                        run_data_reg <= data_reg;
                        run_cmd_reg  <= cmd_reg;
                        ticks_reg    <= op_ticks(cmd_reg,
                                         pump_reg && addr_reg[5:0] != 6'h00); // [R13]
                        state_reg    <= flash_seq_pkg::ST_RUN;
                    end
                end
                flash_seq_pkg::ST_RUN: begin
                    // Next command may be staged while this one runs; buffer is then full.
                    if (link.stop_mode) begin
                        state_reg  <= flash_seq_pkg::ST_IDLE; // [R21]
                        queued_reg <= 1'b0;
                    end else begin
                        if (wr_array && !err_set && cbef_reg) begin
                            addr_reg <= link.wr_addr;
                            data_reg <= link.wr_data;
                            stage_reg <= 2'h1;
                        end
                        if (wr_cmd && !err_set) begin
                            cmd_reg <= link.wr_data;
                            stage_reg <= 2'h2;
                        end
                        if (launch) begin
                            queued_reg <= 1'b1;
                        end
                        if (tick) begin
                            ticks_reg <= ticks_reg - 15'h0001;
                        end
                        if (done && (queued_reg || launch)) begin
                            run_addr_reg <= addr_reg;
                            run_data_reg <= data_reg;
                            run_cmd_reg  <= cmd_reg;
                            ticks_reg    <= op_ticks(cmd_reg, burst_keep);
                            queued_reg   <= 1'b0;
                        end else if (done) begin
                            state_reg <= in_cmd  ? flash_seq_pkg::ST_CMDSET :
                                         in_load ? flash_seq_pkg::ST_LOADED :
                                                   flash_seq_pkg::ST_IDLE;
                        end
                    end
                end
                default: state_reg <= flash_seq_pkg::ST_IDLE;
            endcase
            if (launch) begin
                cbef_reg <= 1'b0; // [R9]
            end else if (done || link.stop_mode || !queued_reg) begin
                cbef_reg <= 1'b1;
            end
            if (err_set || launch || state_reg != flash_seq_pkg::ST_RUN) begin
                stage_reg <= 2'h0;
            end
        end
    end

    // Complete flag drops at launch and rises when nothing is left to run.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ccf_reg <= 1'b1;
        end else if (launch) begin
            ccf_reg <= 1'b0;
        end else if ((done && !queued_reg) ||
                     (link.stop_mode && state_reg == flash_seq_pkg::ST_RUN)) begin
            ccf_reg <= 1'b1; // [R11]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pump_reg <= 1'b0;
        end else if (link.stop_mode || (done && !burst_keep)) begin
            pump_reg <= 1'b0; // [R14]
        end else if (state_reg == flash_seq_pkg::ST_RUN && run_cmd_reg == `CMD_BURST_PROG) begin
            pump_reg <= 1'b1; // [R12]
        end
    end

    assign link.status  = {cbef_reg, ccf_reg, 1'b0, accerr_reg, 3'b000, div_set_reg};
    assign link.divider = div_reg;
    assign link.pump_on = pump_reg;
    assign link.busy    = state_reg == flash_seq_pkg::ST_RUN;
    assign array_addr   = run_addr_reg;
    assign array_data   = run_data_reg;
    assign active_cmd   = run_cmd_reg;
    assign high_voltage = state_reg == flash_seq_pkg::ST_RUN && run_cmd_reg != `CMD_BLANK;
endmodule : flash_seq_device
`default_nettype wire

//--- verilog/flash_seq_host.sv
// APB slave that turns software writes into sequencer link strobes.
// Assumes one pclk domain shared with the device end.
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_map.svh"
module flash_seq_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    flash_seq_if.host        link
);
    logic [15:0] addr_hold_reg;
    logic [2:0]  mode_reg;
    logic        stb_reg;
    logic [1:0]  kind_reg;
    logic [7:0]  data_reg;
    logic        access;
    logic        mapped;

    assign access = psel && penable;
    assign pready = 1'b1;
    assign mapped = paddr == `OFF_DIVIDER || paddr == `OFF_STATUS || paddr == `OFF_COMMAND ||
                    paddr == `OFF_ARRAY_ADDR || paddr == `OFF_ARRAY_DATA ||
                    paddr == `OFF_MODE;
    assign pslverr = access && !mapped;

    // The array data write is the one that carries the array write to the device.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_hold_reg <= 16'h0000;
            mode_reg      <= 3'b000;
            stb_reg       <= 1'b0;
            kind_reg      <= 2'b00;
            data_reg      <= 8'h00;
        end else begin
            stb_reg <= 1'b0;
            if (access && pwrite) begin
                case (paddr)
                    `OFF_ARRAY_ADDR: addr_hold_reg <= pwdata[15:0];
                    `OFF_MODE:       mode_reg <= pwdata[2:0];
                    `OFF_ARRAY_DATA: begin
                        stb_reg  <= 1'b1; // [R6]
                        kind_reg <= flash_seq_pkg::REQ_ARRAY;
                        data_reg <= pwdata[7:0];
                    end
                    `OFF_COMMAND: begin
                        stb_reg  <= 1'b1;
                        kind_reg <= flash_seq_pkg::REQ_CMD;
                        data_reg <= pwdata[7:0];
                    end
                    `OFF_STATUS: begin
                        stb_reg  <= 1'b1; // [R9] [R15]
                        kind_reg <= flash_seq_pkg::REQ_STATUS;
                        data_reg <= pwdata[7:0];
                    end
                    `OFF_DIVIDER: begin
                        stb_reg  <= 1'b1; // [R1]
                        kind_reg <= flash_seq_pkg::REQ_DIV;
                        data_reg <= pwdata[7:0];
                    end
                    default: stb_reg <= 1'b0;
                endcase
            end
        end
    end

    assign link.wr_stb    = stb_reg;
    assign link.wr_kind   = flash_seq_pkg::req_kind_e'(kind_reg);
    assign link.wr_addr   = addr_hold_reg;
    assign link.wr_data   = data_reg;
    assign link.stop_mode = mode_reg[`MODE_STOP];
    assign link.from_bdm  = mode_reg[`MODE_BDM];
    assign link.secured   = mode_reg[`MODE_SECURE];

    always_comb begin
        prdata = 32'h00000000;
        case (paddr)
            `OFF_DIVIDER:    prdata = {25'h0000000, link.divider};
            `OFF_STATUS:     prdata = {22'h000000, link.busy, link.pump_on, link.status};
            `OFF_ARRAY_ADDR: prdata = {16'h0000, addr_hold_reg};
            `OFF_MODE:       prdata = {29'h00000000, mode_reg};
            default:         prdata = 32'h00000000;
        endcase
    end
endmodule : flash_seq_host
`default_nettype wire

//--- verilog/flash_seq_if.sv
// Link between the flash sequencer device end and the APB controller end.
// One write port with a one-cycle strobe, plus status returned by the device.
`timescale 1ns/100ps
`default_nettype none
interface flash_seq_if;
    logic                       wr_stb;
    flash_seq_pkg::req_kind_e   wr_kind;
    logic [15:0]                wr_addr;
    logic [7:0]                 wr_data;
    logic                       from_bdm;
    logic                       secured;
    logic                       stop_mode;
    logic [7:0]                 status;
    logic [6:0]                 divider;
    logic                       pump_on;
    logic                       busy;
    modport device (input wr_stb, wr_kind, wr_addr, wr_data, from_bdm, secured, stop_mode,
                    output status, divider, pump_on, busy);
    modport host   (output wr_stb, wr_kind, wr_addr, wr_data, from_bdm, secured, stop_mode,
                    input status, divider, pump_on, busy);
endinterface : flash_seq_if
`default_nettype wire

//--- verilog/flash_seq_map.svh
// Offsets, field positions, reset values and timing counts of the flash sequencer.
// Included by the package-using design files; holds definitions only.
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH
`define OFF_DIVIDER      12'h000
`define OFF_STATUS       12'h004
`define OFF_COMMAND      12'h008
`define OFF_ARRAY_ADDR   12'h00C
`define OFF_ARRAY_DATA   12'h010
`define OFF_MODE         12'h014
`define BIT_CBEF         7
`define BIT_CCF          6
`define BIT_ACCERR       4
`define BIT_DIVSET       0
`define MODE_STOP        0
`define MODE_BDM         1
`define MODE_SECURE      2
`define DIVIDER_RESET    7'h00
`define CMD_BLANK        8'h05
`define CMD_BYTE_PROG    8'h20
`define CMD_BURST_PROG   8'h25
`define CMD_PAGE_ERASE   8'h40
`define CMD_MASS_ERASE   8'h41
`define TICKS_BYTE       9
`define TICKS_BURST      4
`define TICKS_PAGE       4000
`define TICKS_MASS       20000
`define ERASE_PROGRAM_TIMING_CLOCK_MIN_KHZ     150
`define ERASE_PROGRAM_TIMING_CLOCK_MAX_KHZ     200
`define PCLK_KHZ         20000
`endif

//--- verilog/flash_seq_pkg.sv
// Types shared by the flash sequencer ends and their interface.
// Constants live in flash_seq_map.svh.
package flash_seq_pkg;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_LOADED = 3'b001,
        ST_CMDSET = 3'b010,
        ST_RUN    = 3'b011
    } seq_state_e;
    typedef enum logic [1:0] {
        REQ_ARRAY  = 2'b00,
        REQ_CMD    = 2'b01,
        REQ_STATUS = 2'b10,
        REQ_DIV    = 2'b11
    } req_kind_e;
endpackage : flash_seq_pkg
